// *** pcb_cycle_mem.sv ***
`timescale 1ns/1ns
// per-pump cycle counter store with registered read ports
module pcb_cycle_mem #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 3,
  parameter int RPORTS = 6
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [DEPTH-1:0] inc_in,
  input wire logic [DEPTH-1:0] clear_in,
  input wire logic [WIDTH-1:0] max_in,
  input wire logic [RPORTS-1:0][1:0] raddr_in,
  output logic [RPORTS-1:0][WIDTH-1:0] rdata_out
);
  logic [DEPTH-1:0][WIDTH-1:0] mem;

  // clear wins over a coincident count, it means a new pump was fitted
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          mem[g] <= '0;
        end else if (clear_in[g]) begin
          mem[g] <= '0;
        end else if (inc_in[g] && mem[g] != max_in) begin
          mem[g] <= mem[g] + 1'b1;  // saturates at max
        end
      end
    end
    // read address 0 means not attached, reads zero
    for (g = 0; g < RPORTS; g++) begin : g_rd
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          rdata_out[g] <= '0;
        end else if (raddr_in[g] == 2'd0) begin
          rdata_out[g] <= '0;
        end else begin
          rdata_out[g] <= mem[raddr_in[g] - 2'd1];
        end
      end
    end
  endgenerate
endmodule // pcb_cycle_mem

// *** pcb_pkg.sv ***
// shared types and constants for the pump control blocks
package pcb_pkg;
  localparam int NUM_BLOCKS = 6;
  localparam int NUM_PUMPS = 3;
  localparam int NUM_NORMAL_SRC = 4;
  localparam int NUM_FROST_SRC = 2;
  localparam int NUM_FOFF_SRC = 3;
  localparam int NUM_FON_SRC = 3;
  localparam int TIME_W = 12;
  localparam int DAYS_W = 10;
  localparam int CYCLE_W = 20;
  localparam logic [CYCLE_W-1:0] CYCLE_MAX = 20'h0_F423F;  // 999,999
  localparam int CLK_HZ = 100_000_000;
  localparam int SEC_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * SEC_S;
  localparam int DAY_S = 86_400;
  localparam logic [TIME_W-1:0] TIMER_RESET = 12'h000;
  localparam logic [DAYS_W-1:0] DAYS_RESET = 10'h000;
  localparam logic [CYCLE_W-1:0] CYCLE_RESET = 20'h0_0000;

  typedef enum logic [1:0] {
    PCB_OUT_NONE,
    PCB_OUT_A,
    PCB_OUT_B,
    PCB_OUT_C
  } pcb_out_sel_t;

  typedef struct packed {
    pcb_out_sel_t out_sel;
    logic manual_on;
    logic [NUM_NORMAL_SRC-1:0] normal_en;
    logic [NUM_FROST_SRC-1:0] frost_en;
    logic [NUM_FOFF_SRC-1:0] foff_en;
    logic [NUM_FON_SRC-1:0] fon_en;
    logic [TIME_W-1:0] start_delay;
    logic [TIME_W-1:0] overrun;
  } pcb_cfg_t;

  typedef struct packed {
    logic [NUM_NORMAL_SRC-1:0] normal;
    logic [NUM_FROST_SRC-1:0] frost;
    logic [NUM_FOFF_SRC-1:0] foff;
    logic [NUM_FON_SRC-1:0] fon;
  } pcb_cond_t;
endpackage

// *** pcb_pump_ctrl.sv ***
`timescale 1ns/1ns
// What this block does
// - six identical, freely assignable pump blocks
// - per-block selector: none, pump A, B, C
// - blocks sharing an output are ORed
// - manual-on holds pump on until auto
// - enabled normal demand via delay and overrun
// - enabled frost demand feeds on, force-off inhibits
// - force-off blocks normal and frost, not force-on
// - force-on turns pump on unless master drives X, Y, Z
// - start delay on demand rise, zero disables
// - stand-alone: skip delay if burner firing
// - slave: skip delay if master reports firing
// - overrun holds pump after demand, zero disables
// - local/master service cancels running overrun
// - per-output cycle counter 0..999999, restartable
// - only attached outputs are exercised
// - count off days, run exercise at interval
// - pump on clears its off-day counter
// - shared exercise interval, zero disables
// - shared exercise time, zero disables
// - frost request bits track frost detection
// - frost-firing flag: frost priority, demand, firing or preparing
// - master may drive slave pumps as X, Y, Z
module pcb_pump_ctrl #(
  parameter int SEC_CYCLES = pcb_pkg::SEC_CYCLES,
  parameter int DAY_SECS = pcb_pkg::DAY_S
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire pcb_pkg::pcb_cfg_t [pcb_pkg::NUM_BLOCKS-1:0] cfg_in,
  input wire pcb_pkg::pcb_cond_t cond_in,
  input wire logic slave_mode_in,
  input wire logic burner_firing_in,
  input wire logic master_slave_firing_in,
  input wire logic local_service_in,
  input wire logic master_service_in,
  input wire logic [pcb_pkg::NUM_PUMPS-1:0] cycle_restart_in,
  input wire logic [pcb_pkg::DAYS_W-1:0] exercise_days_in,
  input wire logic [pcb_pkg::TIME_W-1:0] exercise_time_in,
  input wire logic [pcb_pkg::NUM_FROST_SRC-1:0] frost_detect_in,
  input wire logic frost_priority_in,
  input wire logic burner_demand_in,
  input wire logic burner_preparing_in,
  input wire logic remote_xyz_sel_in,
  input wire logic [pcb_pkg::NUM_PUMPS-1:0] remote_xyz_in,
  output logic [pcb_pkg::NUM_PUMPS-1:0] pump_out,
  output logic [pcb_pkg::NUM_BLOCKS-1:0][pcb_pkg::CYCLE_W-1:0] cycles_out,
  output logic [pcb_pkg::NUM_FROST_SRC-1:0] frost_request_out,
  output logic frost_firing_out
);
  localparam int NB = pcb_pkg::NUM_BLOCKS;
  localparam int NP = pcb_pkg::NUM_PUMPS;
  localparam int TW = pcb_pkg::TIME_W;
  localparam int DW = pcb_pkg::DAYS_W;
  localparam int SCW = $clog2(SEC_CYCLES + 1);
  localparam int DCW = $clog2(DAY_SECS + 1);

  // decode of a block selector to a one-hot pump mask
  function automatic logic [NP-1:0] sel_mask(input pcb_pkg::pcb_out_sel_t s);
    case (s)
      pcb_pkg::PCB_OUT_A: sel_mask = 3'b001;
      pcb_pkg::PCB_OUT_B: sel_mask = 3'b010;
      pcb_pkg::PCB_OUT_C: sel_mask = 3'b100;
      default: sel_mask = 3'b000;
    endcase
  endfunction

  // external status passes two flops; config is assumed static/same domain
  logic [11:0] sync1;
  logic [11:0] sync2;
  logic [11:0] raw;
  assign raw = {cond_in.normal, cond_in.frost, cond_in.foff, cond_in.fon};
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end
  logic [9:0] ssync1;
  logic [9:0] ssync2;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ssync1 <= '0;
      ssync2 <= '0;
    end else begin
      ssync1 <= {burner_firing_in, master_slave_firing_in, local_service_in,
                 master_service_in, frost_detect_in, frost_priority_in,
                 burner_demand_in, burner_preparing_in, remote_xyz_sel_in};
      ssync2 <= ssync1;
    end
  end
  pcb_pkg::pcb_cond_t cond;
  assign cond = pcb_pkg::pcb_cond_t'(sync2);
  logic firing_s, mfiring_s, lserv_s, mserv_s, fprio_s, bdem_s, bprep_s;
  logic xyz_sel_s;
  logic [1:0] fdet_s;
  assign {firing_s, mfiring_s, lserv_s, mserv_s, fdet_s, fprio_s, bdem_s,
          bprep_s, xyz_sel_s} = ssync2;
  logic [2:0] rxyz1;
  logic [2:0] rxyz2;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rxyz1 <= '0;
      rxyz2 <= '0;
    end else begin
      rxyz1 <= remote_xyz_in;
      rxyz2 <= rxyz1;
    end
  end

  // second and day tick dividers, one-cycle enables
  logic [SCW-1:0] sec_cnt;
  logic [DCW-1:0] day_cnt;
  logic sec_tick;
  logic day_tick;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sec_cnt <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (sec_cnt == SCW'(SEC_CYCLES - 1));
      sec_cnt <= (sec_cnt == SCW'(SEC_CYCLES - 1)) ? '0 : sec_cnt + 1'b1;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      day_cnt <= '0;
      day_tick <= 1'b0;
    end else begin
      day_tick <= 1'b0;
      if (sec_tick) begin
        day_tick <= (day_cnt == DCW'(DAY_SECS - 1));
        day_cnt <= (day_cnt == DCW'(DAY_SECS - 1)) ? '0 : day_cnt + 1'b1;
      end
    end
  end

  // service that cancels overrun and firing that skips the start delay
  logic cancel_ovr;
  logic skip_delay;
  assign cancel_ovr = slave_mode_in ? mserv_s : lserv_s;
  assign skip_delay = slave_mode_in ? mfiring_s : firing_s;

  // six identical blocks, any one may serve any purpose
  logic [NB-1:0] blk_on;
  logic [NB-1:0][NP-1:0] blk_mask;
  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_blk
      pcb_pkg::pcb_cfg_t c;
      logic dem;
      logic dem_q;
      logic started;
      logic [TW-1:0] dly;
      logic [TW-1:0] ovr;
      logic frost_dem;
      logic foff;
      logic fon;
      logic norm_on;
      assign c = cfg_in[b];
      assign dem = |(cond.normal & c.normal_en);
      assign frost_dem = |(cond.frost & c.frost_en);
      assign foff = |(cond.foff & c.foff_en);
      assign fon = |(cond.fon & c.fon_en);
      assign blk_mask[b] = sel_mask(c.out_sel);

      // start delay: armed on a rising demand, pump starts at expiry
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          dem_q <= 1'b0;
          started <= 1'b0;
          dly <= pcb_pkg::TIMER_RESET;
        end else begin
          dem_q <= dem;
          if (!dem) begin
            started <= 1'b0;
            dly <= pcb_pkg::TIMER_RESET;
          end else if (!dem_q) begin
            if (c.start_delay == '0 || skip_delay) begin
              started <= 1'b1;
            end else begin
              dly <= c.start_delay;
            end
          end else if (!started && sec_tick) begin
            if (dly <= TW'(1)) begin
              started <= 1'b1;  // demand still present here
              dly <= pcb_pkg::TIMER_RESET;
            end else begin
              dly <= dly - 1'b1;
            end
          end
        end
      end

      // overrun: keep pump on after a started demand ends
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ovr <= pcb_pkg::TIMER_RESET;
        end else if (cancel_ovr) begin
          ovr <= pcb_pkg::TIMER_RESET;
        end else if (started && !dem) begin
          ovr <= c.overrun;  // zero means no hold
        end else if (sec_tick && ovr != '0) begin
          ovr <= ovr - 1'b1;
        end
      end

      // started lasts through the cycle demand drops, so the pump
      // bridges into the overrun without a one-cycle dropout
      assign norm_on = started || (ovr != '0);
      // force-on beats force-off; force-off blocks normal and frost
      assign blk_on[b] = c.manual_on || fon ||
                         (!foff && (norm_on || frost_dem));
    end
  endgenerate

  // OR every block onto the output it selects
  logic [NP-1:0] demand_or;
  logic [NP-1:0] attached;
  always_comb begin
    demand_or = '0;
    attached = '0;
    for (int i = 0; i < NB; i++) begin
      demand_or = demand_or | (blk_on[i] ? blk_mask[i] : 3'b000);
      attached = attached | blk_mask[i];
    end
  end

  // exercise per pump output
  logic [NP-1:0][DW-1:0] off_days;
  logic [NP-1:0][TW-1:0] ex_left;
  logic [NP-1:0] next_pump;
  logic ex_enabled;
  assign ex_enabled = (exercise_days_in != '0) &&
                      (exercise_time_in != '0);
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_pump
      // master use of slave pumps overrides local demand
      assign next_pump[p] = xyz_sel_s ? rxyz2[p] :
                            (demand_or[p] || ex_left[p] != '0);
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          off_days[p] <= pcb_pkg::DAYS_RESET;
          ex_left[p] <= pcb_pkg::TIMER_RESET;
        end else if (pump_out[p] || !attached[p] || !ex_enabled) begin
          off_days[p] <= pcb_pkg::DAYS_RESET;
          if (!attached[p] || !ex_enabled) begin
            ex_left[p] <= pcb_pkg::TIMER_RESET;
          end else if (sec_tick && ex_left[p] != '0) begin
            ex_left[p] <= ex_left[p] - 1'b1;
          end
        end else if (off_days[p] >= exercise_days_in) begin
          ex_left[p] <= exercise_time_in;
          off_days[p] <= pcb_pkg::DAYS_RESET;
        end else if (day_tick) begin
          off_days[p] <= off_days[p] + 1'b1;
        end
      end
    end
  endgenerate

  // registered pump drive; rising edges count a cycle
  logic [NP-1:0] cyc_inc;
  assign cyc_inc = next_pump & ~pump_out;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pump_out <= '0;
    end else begin
      pump_out <= next_pump;
    end
  end

  // cycle counters, each block reads its selected pump
  logic [NB-1:0][1:0] raddr;
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      raddr[i] = 2'(cfg_in[i].out_sel);
    end
  end
  pcb_cycle_mem #(
    .WIDTH(pcb_pkg::CYCLE_W),
    .DEPTH(NP),
    .RPORTS(NB)
  ) u_cycles (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .inc_in(cyc_inc),
    .clear_in(cycle_restart_in),
    .max_in(pcb_pkg::CYCLE_MAX),
    .raddr_in(raddr),
    .rdata_out(cycles_out)
  );

  // frost requests and frost-firing status
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frost_request_out <= '0;
      frost_firing_out <= 1'b0;
    end else begin
      frost_request_out <= fdet_s;
      frost_firing_out <= fprio_s && bdem_s &&
                          (firing_s || bprep_s);
    end
  end
endmodule // pcb_pump_ctrl

// *** pcb_pump_ctrl_sva.sv ***
`timescale 1ns/1ns
// port-level checker for the pump control blocks
module pcb_pump_ctrl_sva (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire pcb_pkg::pcb_cfg_t [pcb_pkg::NUM_BLOCKS-1:0] cfg_in,
  input wire pcb_pkg::pcb_cond_t cond_in,
  input wire logic [pcb_pkg::NUM_PUMPS-1:0] cycle_restart_in,
  input wire logic [pcb_pkg::DAYS_W-1:0] exercise_days_in,
  input wire logic [pcb_pkg::NUM_FROST_SRC-1:0] frost_detect_in,
  input wire logic frost_priority_in,
  input wire logic burner_demand_in,
  input wire logic burner_firing_in,
  input wire logic burner_preparing_in,
  input wire logic remote_xyz_sel_in,
  input wire logic [pcb_pkg::NUM_PUMPS-1:0] remote_xyz_in,
  input wire logic [pcb_pkg::NUM_PUMPS-1:0] pump_out,
  input wire logic [pcb_pkg::NUM_BLOCKS-1:0][pcb_pkg::CYCLE_W-1:0] cycles_out,
  input wire logic [pcb_pkg::NUM_FROST_SRC-1:0] frost_request_out,
  input wire logic frost_firing_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [1:0] up;
  logic [2:0] att, on_rq, off_rq;
  // cycles since reset, so $past never looks into the reset span
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  // per pump: attached, forced or manual on, every block forced off
  always_comb begin
    att = '0;
    on_rq = '0;
    off_rq = 3'h7;
    for (int b = 0; b < 6; b++) begin
      for (int p = 0; p < 3; p++) begin
        if (int'(cfg_in[b].out_sel) == p + 1) begin
          att[p] = 1'b1;
          if (cfg_in[b].manual_on || |(cond_in.fon & cfg_in[b].fon_en))
            on_rq[p] = 1'b1;
          if (!(|(cond_in.foff & cfg_in[b].foff_en)))
            off_rq[p] = 1'b0;
        end
      end
    end
    off_rq = off_rq & ~on_rq;
  end
  for (genvar p = 0; p < 3; p++) begin : g_p
    AST_ON: assert property ((on_rq[p] && !remote_xyz_sel_in)[*5]
      |-> pump_out[p]) else $error("forced pump not on");
    AST_DETACHED: assert property ((!att[p] && !remote_xyz_sel_in)[*5]
      |-> !pump_out[p]) else $error("unattached pump on");
    AST_FOFF: assert property ((off_rq[p] && !remote_xyz_sel_in &&
      exercise_days_in == '0)[*5] |-> !pump_out[p])
      else $error("forced-off pump on");
  end
  for (genvar b = 0; b < 6; b++) begin : g_b
    AST_CYC_MAX: assert property (cycles_out[b] <= pcb_pkg::CYCLE_MAX)
      else $error("cycle count above range");
    AST_CYC_NONE: assert property (
      (cfg_in[b].out_sel == pcb_pkg::PCB_OUT_NONE)[*3] |-> cycles_out[b] == '0)
      else $error("detached block shows cycles");
    AST_CYC_CLR: assert property ((cfg_in[b].out_sel != pcb_pkg::PCB_OUT_NONE
      && cycle_restart_in[int'(cfg_in[b].out_sel) - 1])[*4]
      |-> cycles_out[b] == '0) else $error("restart did not clear");
  end
  AST_REMOTE: assert property ((remote_xyz_sel_in && $stable(remote_xyz_in))[*5]
    |-> pump_out == remote_xyz_in) else $error("remote pumps not followed");
  AST_FROST_REQ: assert property (up == 2'h3
    |-> frost_request_out == $past(frost_detect_in, 3))
    else $error("frost request not tracking");
  AST_FROST_FIRE: assert property (up == 2'h3 |-> frost_firing_out ==
    $past(frost_priority_in && burner_demand_in &&
    (burner_firing_in || burner_preparing_in), 3))
    else $error("frost firing flag wrong");
  // main scenarios reached
  cover property ($rose(pump_out[0]));
  cover property ($rose(frost_firing_out));
  cover property (remote_xyz_sel_in && pump_out != '0);
endmodule // pcb_pump_ctrl_sva

bind pcb_pump_ctrl pcb_pump_ctrl_sva i_pcb_pump_ctrl_sva (
  .sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in),
  .cfg_in(cfg_in),
  .cond_in(cond_in),
  .cycle_restart_in(cycle_restart_in),
  .exercise_days_in(exercise_days_in),
  .frost_detect_in(frost_detect_in),
  .frost_priority_in(frost_priority_in),
  .burner_demand_in(burner_demand_in),
  .burner_firing_in(burner_firing_in),
  .burner_preparing_in(burner_preparing_in),
  .remote_xyz_sel_in(remote_xyz_sel_in),
  .remote_xyz_in(remote_xyz_in),
  .pump_out(pump_out),
  .cycles_out(cycles_out),
  .frost_request_out(frost_request_out),
  .frost_firing_out(frost_firing_out)
);

// *** pcb_relay_model.sv ***
`timescale 1ns/1ns
// far-side pump relay model: counts coil pull-ins per relay
module pcb_relay_model (
  input wire logic sys_clk_in,
  input wire logic [2:0] pump_in,
  output logic [2:0][7:0] starts_out
);
  logic [2:0] prev = '0;
  initial starts_out = '0;
  // a relay pulls in only on a rising coil drive, like the real contactor
  always @(posedge sys_clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (pump_in[i] && !prev[i]) begin
        starts_out[i] <= starts_out[i] + 8'h01;
      end
    end
    prev <= pump_in;
  end
endmodule // pcb_relay_model

// *** tb.sv ***
`timescale 1ns/1ns
// self-checking testbench for the pump control blocks
module tb;
  logic clk = 0, rst_b = 0, slv = 0, fir = 0, mfir = 0, lsv = 0, msv = 0;
  logic prio = 0, dem = 0, prep = 0, rsel = 0, ffire;
  logic [2:0] rcyc = 0, rxyz = 0, pump;
  logic [9:0] exd = 0;
  logic [11:0] ext = 0;
  logic [1:0] fdet = 0, freq;
  logic [5:0][19:0] cyc;
  logic [2:0][7:0] starts;
  pcb_pkg::pcb_cfg_t [5:0] cfg = '0;
  pcb_pkg::pcb_cond_t cond = '0;
  int n_mismatch = 0, num_checks = 0, t;
  // one second is 10 clocks, one day 4 seconds
  pcb_pump_ctrl #(.SEC_CYCLES(10), .DAY_SECS(4)) i_pcb_pump_ctrl (
    .sys_clk_in(clk), .rst_b_in(rst_b), .cfg_in(cfg), .cond_in(cond),
    .slave_mode_in(slv), .burner_firing_in(fir),
    .master_slave_firing_in(mfir), .local_service_in(lsv),
    .master_service_in(msv), .cycle_restart_in(rcyc),
    .exercise_days_in(exd), .exercise_time_in(ext),
    .frost_detect_in(fdet), .frost_priority_in(prio),
    .burner_demand_in(dem), .burner_preparing_in(prep),
    .remote_xyz_sel_in(rsel), .remote_xyz_in(rxyz), .pump_out(pump),
    .cycles_out(cyc), .frost_request_out(freq), .frost_firing_out(ffire));
  pcb_relay_model i_pcb_relay_model (.sys_clk_in(clk), .pump_in(pump),
    .starts_out(starts));
  initial forever #5 clk = ~clk;
  task chk(string n, logic [19:0] s, logic [19:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task cy(int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait for pump p to reach v; t holds the clocks waited
  task wp(int p, logic v, int lim);
    t = 0;
    while (pump[p] !== v && t < lim) begin
      @(negedge clk);
      t++;
    end
    chk("pump", pump[p], v);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // start delay and overrun, cycle count seen by both blocks on pump A
  task t_delay;
    cfg[0] = '{out_sel: pcb_pkg::PCB_OUT_A, normal_en: 4'h1,
      start_delay: 12'h003, overrun: 12'h002, default: '0};
    cfg[1].out_sel = pcb_pkg::PCB_OUT_A;
    cy(2);
    cond.normal[0] = 1;
    wp(0, 1, 60);
    chk("delay", t >= 20, 1);
    cond.normal[0] = 0;
    wp(0, 0, 60);
    chk("overrun", t >= 8, 1);
    cy(3);
    chk("cyc0", cyc[0], 20'h0_0001);
    chk("cyc1", cyc[1], 20'h0_0001);
  endtask
  // delay skipped when firing, overrun cancelled by service
  task t_skip;
    fir = 1;
    cy(4);
    cond.normal[0] = 1;
    wp(0, 1, 8);
    cond.normal[0] = 0;
    lsv = 1;
    wp(0, 0, 8);
    {fir, lsv, slv, mfir} = 4'h3;
    cy(4);
    cond.normal[0] = 1;
    wp(0, 1, 8);
    cond.normal[0] = 0;
    msv = 1;
    wp(0, 0, 8);
    {slv, mfir, msv} = 3'h0;
  endtask
  // frost, force-off, force-on and manual on shared pump B
  task t_force;
    cfg[2] = '{out_sel: pcb_pkg::PCB_OUT_B, frost_en: 2'h1, foff_en: 3'h1,
      default: '0};
    cfg[3] = '{out_sel: pcb_pkg::PCB_OUT_B, fon_en: 3'h2, foff_en: 3'h1,
      default: '0};
    cond.frost[0] = 1;
    wp(1, 1, 8);
    cond.foff[0] = 1;
    wp(1, 0, 8);
    cond.fon[1] = 1;
    wp(1, 1, 8);
    chk("pump_a", pump[0], 0);
    cond = '0;
    wp(1, 0, 8);
    cfg[3].manual_on = 1;
    wp(1, 1, 4);
    cy(30);
    chk("manual", pump[1], 1);
    cfg[3].manual_on = 0;
    wp(1, 0, 4);
  endtask
  // frost flags, remote pumps, relay agreement and counter restart
  task t_misc;
    {fdet, prio, dem, prep} = 5'h0F;
    cy(4);
    chk("freq", freq, 2'h1);
    chk("ffire", ffire, 1);
    prep = 0;
    cy(4);
    chk("ffire_off", ffire, 0);
    {fdet, prio, dem} = 4'h0;
    cy(4);
    chk("freq_off", freq, 2'h0);
    chk("relay", cyc[0], {12'h000, starts[0]});
    rsel = 1;
    rxyz = 3'h5;
    cy(5);
    chk("remote", pump, 3'h5);
    {rsel, rxyz} = 4'h0;
    rcyc = 3'h1;
    cy(4);
    chk("restart", cyc[0], 20'h0_0000);
    rcyc = 3'h0;
  endtask
  // exercise only pump C, with zero settings disabling it
  task t_exercise;
    cfg = '0;
    cfg[4].out_sel = pcb_pkg::PCB_OUT_C;
    ext = 12'h001;
    cy(200);
    chk("ex_days0", pump, 3'h0);
    {exd, ext} = {10'h002, 12'h000};
    cy(200);
    chk("ex_time0", pump, 3'h0);
    ext = 12'h001;
    wp(2, 1, 200);
    chk("ex_ab", pump[1:0], 2'h0);
    wp(2, 0, 30);
    chk("ex_len", t >= 8, 1);
    wp(2, 1, 200);
    chk("ex_restart", t >= 40, 1);
    exd = 10'h000;
    wp(2, 0, 30);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1;
    cy(2);
    t_delay;
    t_skip;
    t_force;
    t_misc;
    t_exercise;
    finish_test;
  end
  // hang guard, about twenty-five times the expected run
  initial begin
    #200_000;
    n_mismatch++;
    finish_test;
  end
endmodule // tb
